// >>> core/serial_tx_ack.sv
// Transmit path, early transmit-done, flow control, flush and LEDs.
// Assumes an outside baud divider gives i_bit_tick, one pulse per bit.
// Notes on behaviour
// - Report done early by lead characters
// - Chain fresh characters without idle gap
// - Hold transmission while flow control stops
// - Flush discards every queued character
// - Drive TXD DTR RTS, sample modem inputs
// - Red lit while powered
// - Green off while port is closed
// - Green steady while port is open and idle
// - Green blinks fast during serial activity
// - Auto lead from baud, zero when external
// - Lead is rounded baud over bits thousand
`timescale 1ns/10ps

module serial_tx_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_flush,
  input  wire logic [W-1:0]               i_data,
  input  wire logic                       i_valid,
  output logic                            o_ready,
  output logic [W-1:0]                    o_data,
  output logic                            o_valid,
  input  wire logic                       i_ready,
  output logic [$clog2(DEPTH):0]          o_count
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;
  fifo_state_t s;
  fifo_state_t next_s;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;

  assign o_count = s.wr - s.rd;
  assign o_valid = (s.wr != s.rd);
  assign o_ready = (o_count != (AW + 1)'(DEPTH)) && !i_flush;
  assign o_data  = mem[s.rd[AW-1:0]];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready && !i_flush;

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.wr = s.wr + 1'b1;
    end
    if (pop)
    begin
      next_s.rd = s.rd + 1'b1;
    end
    if (i_flush)
    begin
      next_s.rd = s.wr;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[s.wr[AW-1:0]] <= i_data;
    end
  end

  a_flush_empties: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_flush |=> (o_count == '0))
    else $error("flush left characters queued");
endmodule

module serial_tx_ack #(
  parameter longint BLINK_CYC = serial_tx_ack_pkg::BLINK_CYC_DEF,
  parameter longint ACT_CYC   = serial_tx_ack_pkg::ACT_CYC_DEF
) (
  input  wire logic                                    i_clk,
  input  wire logic                                    i_reset_n,
  input  wire logic [serial_tx_ack_pkg::DATA_W-1:0]    i_wr_data,
  input  wire logic                                    i_wr_valid,
  output logic                                         o_wr_ready,
  input  wire logic                                    i_flush,
  output logic                                         o_tx_done,
  input  wire logic                                    i_bit_tick,
  input  wire logic                                    i_flow_en,
  input  wire logic                                    i_ack_auto,
  input  wire logic                                    i_ext_clock,
  input  wire logic [serial_tx_ack_pkg::LEAD_W-1:0]    i_ack_manual,
  input  wire logic [serial_tx_ack_pkg::BAUD_W-1:0]    i_baud,
  input  wire logic [serial_tx_ack_pkg::BITS_W-1:0]    i_char_bits,
  input  wire logic                                    i_dtr_req,
  input  wire logic                                    i_rts_req,
  output logic                                         o_txd,
  output logic                                         o_dtr,
  output logic                                         o_rts,
  input  wire logic                                    i_rxd,
  input  wire logic                                    i_dcd,
  input  wire logic                                    i_dsr,
  input  wire logic                                    i_cts,
  input  wire logic                                    i_ri,
  output logic [serial_tx_ack_pkg::SYNC_N-1:0]         o_modem_in,
  input  wire logic                                    i_rx_active,
  input  wire logic                                    i_usb_powered,
  input  wire logic                                    i_port_open,
  output logic                                         o_led_red,
  output logic                                         o_led_green
);
  import serial_tx_ack_pkg::*;
  localparam logic [CNT_W-1:0] BLINK_RELOAD = CNT_W'(BLINK_CYC - 1);
  localparam logic [CNT_W-1:0] ACT_RELOAD   = CNT_W'(ACT_CYC);

  typedef struct packed {
    logic [SYNC_N-1:0] s1;
    logic [SYNC_N-1:0] s2;
    tx_state_t         st;
    logic [DATA_W:0]   shreg;
    logic [BITS_W-1:0] bitn;
    logic              txd;
    logic              dtr;
    logic              rts;
    logic              pending;
    logic              done;
    logic [CNT_W-1:0]  act;
    logic [CNT_W-1:0]  blk;
    logic              blink;
    logic              red;
    logic              green;
  } top_state_t;
  top_state_t s;
  top_state_t next_s;

  // ----------------------------------------------------------------
  // Queue and lead
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]               q_data;
  logic                            q_valid;
  logic                            q_pop;
  logic [$clog2(FIFO_DEPTH):0]     q_count;
  logic [LEAD_W:0]                 outstanding;
  logic [BAUD_W:0]                 num;
  logic [13:0]                     den;
  logic [BAUD_W:0]                 quot;
  logic [LEAD_W-1:0]               calc_lead;
  logic [LEAD_W-1:0]               lead;
  logic [LEAD_W-1:0]               eff_lead;
  logic                            stall;
  logic                            last_bit;
  logic                            start_ok;
  logic                            ack_now;
  logic                            act_start;

  serial_tx_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_flush   (i_flush),
    .i_data    (i_wr_data),
    .i_valid   (i_wr_valid),
    .o_ready   (o_wr_ready),
    .o_data    (q_data),
    .o_valid   (q_valid),
    .i_ready   (q_pop),
    .o_count   (q_count)
  );

  assign num  = (BAUD_W + 1)'(i_baud) + (BAUD_W + 1)'(13'(i_char_bits) * LEAD_HALF);
  assign den  = 14'(i_char_bits) * LEAD_SCALE;
  assign quot = (den == '0) ? '0 : num / (BAUD_W + 1)'(den);
  assign calc_lead = (quot > (BAUD_W + 1)'(LEAD_MAX)) ? LEAD_MAX : quot[LEAD_W-1:0];
  assign lead = !i_ack_auto ? i_ack_manual : (i_ext_clock ? '0 : calc_lead);
  assign eff_lead    = stall ? '0 : lead;
  assign stall       = i_flow_en && !s.s2[SYNC_CTS];
  assign outstanding = (LEAD_W + 1)'(q_count) + (LEAD_W + 1)'(s.st == TX_SHIFT);
  assign last_bit    = (s.bitn == i_char_bits - 1'b1);
  assign start_ok    = i_bit_tick && q_valid && !stall && !i_flush;
  assign q_pop       = start_ok && ((s.st == TX_IDLE) || last_bit);
  assign ack_now     = s.pending && (outstanding <= (LEAD_W + 1)'(eff_lead));
  assign act_start   = q_pop || i_rx_active;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.s1 = {i_ri, i_cts, i_dsr, i_dcd, i_rxd};
    next_s.s2 = s.s1;
    next_s.dtr = i_dtr_req;
    next_s.rts = i_rts_req;
    case (s.st)
      TX_IDLE:
      begin
        if (q_pop)
        begin
          next_s.shreg = {q_data, START_BIT};
          next_s.bitn  = '0;
          next_s.st    = TX_SHIFT;
        end
      end
      TX_SHIFT:
      begin
        if (i_bit_tick)
        begin
          if (last_bit && q_pop)
          begin
            next_s.shreg = {q_data, START_BIT};
            next_s.bitn  = '0;
          end
          else if (last_bit)
          begin
            next_s.st = TX_IDLE;
          end
          else
          begin
            next_s.shreg = {LINE_IDLE, s.shreg[DATA_W:1]};
            next_s.bitn  = s.bitn + 1'b1;
          end
        end
      end
      default:
      begin
        next_s.st = TX_IDLE;
      end
    endcase
    next_s.txd = (next_s.st == TX_SHIFT) ? next_s.shreg[0] : LINE_IDLE;
    next_s.done    = ack_now;
    next_s.pending = (o_wr_ready && i_wr_valid) || (s.pending && !ack_now && !i_flush);
    if (act_start)
    begin
      next_s.act = ACT_RELOAD;
    end
    else if (s.act != '0)
    begin
      next_s.act = s.act - 1'b1;
    end
    if (s.act == '0)
    begin
      next_s.blk   = '0;
      next_s.blink = 1'b0;
    end
    else if (s.blk == '0)
    begin
      next_s.blk   = BLINK_RELOAD;
      next_s.blink = !s.blink;
    end
    else
    begin
      next_s.blk = s.blk - 1'b1;
    end
    next_s.red = i_usb_powered;
    next_s.green = i_usb_powered && i_port_open && ((next_s.act == '0) || next_s.blink);
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s       <= '0;
      s.st    <= TX_IDLE;
      s.txd   <= LINE_IDLE;
      s.shreg <= '1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_txd       = s.txd;
  assign o_dtr       = s.dtr;
  assign o_rts       = s.rts;
  assign o_modem_in  = s.s2;
  assign o_tx_done   = s.done;
  assign o_led_red   = s.red;
  assign o_led_green = s.green;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_early_done: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (ack_now && !(o_wr_ready && i_wr_valid)) |=> o_tx_done ##1 !o_tx_done)
    else $error("early done not pulsed");
  a_back_to_back: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (s.st == TX_SHIFT && last_bit && q_pop) |=> (s.st == TX_SHIFT && s.bitn == '0 && !o_txd))
    else $error("gap between chained characters");
  a_flow_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (s.st == TX_IDLE && stall) |=> (s.st == TX_IDLE && o_txd))
    else $error("transmit started while held");
  a_idle_line: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (s.st == TX_IDLE) |-> o_txd)
    else $error("line not idle high");
  a_red_power: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $changed(i_usb_powered) |=> (o_led_red == $past(i_usb_powered)))
    else $error("red does not track power");
  a_green_closed: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_port_open |=> !o_led_green)
    else $error("green lit on closed port");
  a_green_steady: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_usb_powered && i_port_open && s.act == '0 && !act_start) |=> o_led_green)
    else $error("green not steady");
  a_blink_toggle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (s.act != '0 && s.blk == '0) |=> (s.blink != $past(s.blink) && s.blk == BLINK_RELOAD))
    else $error("blink did not toggle");
  a_ext_lead_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ack_auto && i_ext_clock) |-> (lead == '0))
    else $error("lead not zero on external clock");
  a_lead_round: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (den != '0 && quot <= (BAUD_W + 1)'(LEAD_MAX)) |->
      (36'(quot) * 36'(den) <= 36'(num) && 36'(num) < (36'(quot) + 36'h1) * 36'(den)))
    else $error("lead rounding wrong");
  a_act_stretch: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    act_start |=> (s.act == ACT_RELOAD) ##1 (s.act != '0))
    else $error("activity not stretched");
endmodule

// >>> shared/serial_tx_ack_pkg.sv
// Constants and types for the serial port transmit-acknowledge block.
// Assumes a single 100 MHz clock and an external baud-tick divider.
package serial_tx_ack_pkg;
  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int BAUD_W     = 21;
  localparam int BITS_W     = 4;
  localparam int LEAD_W     = 8;
  localparam int CNT_W      = 32;
  // ----------------------------------------------------------------
  // Lead calculation
  // ----------------------------------------------------------------
  localparam logic [13:0]       LEAD_SCALE = 14'h3e8;
  localparam logic [12:0]       LEAD_HALF  = 13'h1f4;
  localparam logic [LEAD_W-1:0] LEAD_MAX   = 8'hff;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ   = 100_000_000;
  localparam longint BLINK_MS = 50;
  localparam longint ACT_MS   = 200;
  localparam longint BLINK_CYC_DEF = (CLK_HZ * BLINK_MS) / 1000;
  localparam longint ACT_CYC_DEF   = (CLK_HZ * ACT_MS) / 1000;
  // ----------------------------------------------------------------
  // Pin synchroniser slots and line levels
  // ----------------------------------------------------------------
  localparam int SYNC_N   = 5;
  localparam int SYNC_RXD = 0;
  localparam int SYNC_DCD = 1;
  localparam int SYNC_DSR = 2;
  localparam int SYNC_CTS = 3;
  localparam int SYNC_RI  = 4;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_BIT = 1'b0;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;
endpackage

// >>> sim/remote_serial_model.sv
// Remote serial device model: decodes the transmit line, drives clear to send.
// Assumes the bench bit tick, one pulse per serial bit, 8 data bits LSB first.
`timescale 1ns/10ps

module remote_serial_model (
  input  wire logic       i_clk,
  input  wire logic       i_tick,
  input  wire logic       i_txd,
  input  wire logic [3:0] i_char_bits,
  input  wire logic       i_hold,
  input  wire logic       i_clr,
  output logic            o_cts,
  output int              o_count,
  output int              o_gaps
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  int         bit_n;
  logic       seen;

  assign o_cts = !i_hold;

  always @(posedge i_clk)
    if (i_clr)
    begin
      rx_q = {};
      o_count = 0;
      o_gaps = 0;
      bit_n = 0;
      seen = 1'b0;
    end
    else if (i_tick)
    begin
      if (bit_n == 0)
      begin
        if (i_txd == 1'b0)
        begin
          bit_n = 1;
          seen = 1'b1;
        end
        else if (seen)
          o_gaps++;
      end
      else if (bit_n <= 8)
      begin
        sh = {i_txd, sh[7:1]};
        bit_n++;
        if (bit_n == 9)
        begin
          rx_q.push_back(sh);
          o_count++;
        end
      end
      else
        bit_n = (bit_n + 1 >= i_char_bits) ? 0 : bit_n + 1;
    end
endmodule

// >>> sim/serial_tx_ack_tb.sv
// Bench for serial_tx_ack: stall, lead, flush, full buffer, pins, LEDs.
// Assumes the package, design and remote model are compiled first.
`timescale 1ns/10ps

module serial_tx_ack_tb;
  import serial_tx_ack_pkg::*;
  localparam int BPER = 4;
  logic              clk, tick = 0, flush = 0, hold = 1, clr = 1;
  logic              reset_n = 0, wr_valid = 0, flow_en = 1, ack_auto = 0;
  logic              ext_clock = 0, dtr_req = 0, rts_req = 0, rx_active = 0;
  logic              powered = 1, port_open = 1, cts;
  logic              wr_ready, tx_done, txd, dtr, rts, led_red, led_green;
  logic [DATA_W-1:0] wr_data = 0;
  logic [LEAD_W-1:0] ack_manual = 0;
  logic [BAUD_W-1:0] baud = 0;
  logic [BITS_W-1:0] char_bits = 10;
  logic [SYNC_N-1:0] pin = 0, modem_in;
  logic [7:0]        exp_q[$];
  int                errors = 0, cmp_count = 0, cyc = 0, tcnt = 0;
  int                done_cnt = 0, at_done = 0, far_count, far_gaps;

  serial_tx_ack #(.BLINK_CYC(4), .ACT_CYC(20)) u_dut (
    .i_clk(clk), .i_reset_n(reset_n), .i_wr_data(wr_data), .i_wr_valid(wr_valid),
    .o_wr_ready(wr_ready), .i_flush(flush), .o_tx_done(tx_done), .i_bit_tick(tick),
    .i_flow_en(flow_en), .i_ack_auto(ack_auto), .i_ext_clock(ext_clock),
    .i_ack_manual(ack_manual), .i_baud(baud), .i_char_bits(char_bits),
    .i_dtr_req(dtr_req), .i_rts_req(rts_req), .o_txd(txd), .o_dtr(dtr), .o_rts(rts),
    .i_rxd(pin[0]), .i_dcd(pin[1]), .i_dsr(pin[2]), .i_cts(cts), .i_ri(pin[4]),
    .o_modem_in(modem_in), .i_rx_active(rx_active), .i_usb_powered(powered),
    .i_port_open(port_open), .o_led_red(led_red), .o_led_green(led_green));

  remote_serial_model u_far (
    .i_clk(clk), .i_tick(tick), .i_txd(txd), .i_char_bits(char_bits), .i_hold(hold),
    .i_clr(clr), .o_cts(cts), .o_count(far_count), .o_gaps(far_gaps));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge clk)
  begin
    tcnt = (tcnt + 1) % BPER;
    tick <= (tcnt == 0);
    if (tx_done === 1'b1)
    begin
      if (done_cnt == 0)
        at_done = far_count;
      done_cnt++;
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic cmp(string name, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (e !== g)
    begin
      errors++;
      $display("BAD %s exp %0h got %0h", name, e, g);
    end
  endtask

  task automatic wt(int n);
    repeat (n) @(negedge clk);
  endtask

  // --------------------------------------------------------------
  // Stalled fill, release, then check line, done and lead
  // --------------------------------------------------------------
  task automatic run(bit au, bit ex, int man, int bd, int bits, int n, bit fl);
    logic [7:0] d;
    int         ld;
    int         k;
    ack_auto = au;
    ext_clock = ex;
    ack_manual = 8'(man);
    baud = 21'(bd);
    char_bits = 4'(bits);
    ld = !au ? man : ex ? 0 : (bd + bits * 500) / (bits * 1000);
    hold = 1'b1;
    clr = 1'b1;
    wt(4);
    clr = 1'b0;
    done_cnt = 0;
    exp_q = {};
    wr_valid = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      wr_data = d;
      exp_q.push_back(d);
      while (wr_ready !== 1'b1)
        @(negedge clk);
      @(negedge clk);
    end
    wr_valid = 1'b0;
    if (n == FIFO_DEPTH)
      cmp("full", 0, wr_ready);
    wt(40);
    cmp("stall_cnt", 0, far_count);
    cmp("stall_done", 0, done_cnt);
    if (fl)
    begin
      flush = 1'b1;
      wt(1);
      flush = 1'b0;
      exp_q = {};
    end
    hold = 1'b0;
    k = 0;
    while (far_count < exp_q.size() && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    cmp("gaps", 0, far_gaps);
    wt(BPER * 16 + 10);
    cmp("count", exp_q.size(), far_count);
    cmp("done_n", fl ? 0 : 1, done_cnt);
    if (!fl)
      cmp("lead", n - ld, at_done);
    foreach (exp_q[i])
      cmp("byte", exp_q[i], u_far.rx_q[i]);
  endtask

  initial
  begin
    int z;
    int z2;
    void'($urandom(37));
    wt(5);
    cmp("txd_idle", 1, txd);
    reset_n = 1'b1;
    run(0, 0, 2, 0, 10, 6, 0);
    run(1, 1, 5, 0, 10, 6, 0);
    run(1, 0, 0, 25000, 10, 6, 0);
    run(1, 0, 0, 11000, 11, 6, 0);
    run(0, 0, 3, 0, 10, 16, 1);
    run(0, 0, 1, 0, 10, 16, 0);
    for (int i = 0; i < 8; i++)
    begin
      {dtr_req, rts_req} = 2'($urandom);
      pin = 5'($urandom);
      hold = ~pin[SYNC_CTS];
      wt(1);
      cmp("dtr", dtr_req, dtr);
      cmp("rts", rts_req, rts);
      wt(3);
      cmp("modem", pin, modem_in);
    end
    hold = 1'b0;
    powered = 1'b0;
    wt(3);
    cmp("red_off", 0, led_red);
    cmp("grn_off", 0, led_green);
    powered = 1'b1;
    port_open = 1'b0;
    wt(3);
    cmp("red_on", 1, led_red);
    cmp("grn_free", 0, led_green);
    port_open = 1'b1;
    wt(3);
    cmp("grn_open", 1, led_green);
    rx_active = 1'b1;
    wt(1);
    rx_active = 1'b0;
    z = 0;
    z2 = 0;
    for (int i = 0; i < 20; i++)
    begin
      wt(1);
      z += (led_green === 1'b0);
      z2 += (i >= 12 && led_green === 1'b0);
    end
    cmp("blink", 1, z > 0);
    cmp("stretch", 1, z2 > 0);
    wt(10);
    cmp("grn_back", 1, led_green);
    close_out();
  end
endmodule
